// [src/sd_host_control.sv]
// Function
// - Card clock output stops while card clock enable is clear, runs when set.
// - Present state reports internal card clock stable after reset or divider change.
// - Reset-all abandons any command or data operation in progress.
// - No command issued and no data moved while card clock disabled.
// - High card detect level means card inserted.
// - DMA engine knows TRANS, LINK, NOP descriptors; End bit marks last.
// - System clock hold on disables auto-gating; clearing it re-enables gating.
// - DMA read completion sets DMA and transfer-complete flags; DMA flag clearable.
// - DAT1 low is card interrupt; flag sets when both enables are set.
// - Card interrupt flag clears by writing one.
// - Clearing DAT3 detect select forces inverted DAT1 low; re-setting catches edge.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sd_host_map.svh"
module sd_host_control #(
	parameter int DIV_W = 8
) (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// Register port
	input  wire sd_host_pkg::bus_req_t busReq,
	output logic [31:0]               rdData,
	// Card pins
	input  wire logic                 cardDetect,
	input  wire logic                 dat1In,
	output logic                      cardClk,
	output logic                      cmdStart,
	// DMA engine side
	input  wire logic                 descValid,
	input  wire logic [1:0]           descKind,
	input  wire logic                 descEnd,
	input  wire logic                 dataReadDone,
	output logic                      dmaStep,
	// System clock gating
	output logic                      sysClkGateEn
);
	import sd_host_pkg::*;

	// Register storage
	logic [31:0]      sysctl_ff;
	logic [31:0]      statEn_ff;
	logic [31:0]      sigEn_ff;
	logic [31:0]      protocol_ff;
	logic             tcFlag_ff;
	logic             dmaFlag_ff;
	logic             cardIrq_ff;
	logic [DIV_W-1:0] divCnt_ff;
	logic             clkInt_ff;
	logic             cardClk_ff;
	logic [7:0]       stableCnt_ff;
	logic [31:0]      rdData_ff;
	logic             cdS1_ff, cdS2_ff;
	logic             d1S1_ff, d1S2_ff;
	logic             invDat1_ff;
	logic             irqOn_ff;
	xfer_state_t      xfer_ff;

	// Address decode
	wire wrSys   = busReq.wr && busReq.addr == `SYSCTL_OFS;
	wire wrStat  = busReq.wr && busReq.addr == `IRQ_STATUS_REG_OFS;
	wire wrStEn  = busReq.wr && busReq.addr == `IRQ_STATUS_ENABLE_REG_OFS;
	wire wrSgEn  = busReq.wr && busReq.addr == `IRQ_SIGNAL_ENABLE_REG_OFS;
	wire wrProt  = busReq.wr && busReq.addr == `PROTOCOL_OFS;
	wire wrXfer  = busReq.wr && busReq.addr == `XFER_OFS;
	wire resetAll = wrSys && busReq.wdata[`RSTALL_BIT];
	wire divChange = wrSys && busReq.wdata[`DIVLO_BIT+DIV_W-1:`DIVLO_BIT]
		!= sysctl_ff[`DIVLO_BIT+DIV_W-1:`DIVLO_BIT];

	// Clock and enable state
	wire cardClkEn  = sysctl_ff[`CLKEN_BIT];
	wire holdOn     = sysctl_ff[`HOLD_BIT];
	wire [DIV_W-1:0] divVal = sysctl_ff[`DIVLO_BIT+DIV_W-1:`DIVLO_BIT];
	wire clkStable  = stableCnt_ff == 8'h00;
	wire cardInserted = cdS2_ff;
	wire cirqEnabled = statEn_ff[`CIRQ_BIT] && sigEn_ff[`CIRQ_BIT];
	wire dat3_detect_select       = protocol_ff[`DAT3_DETECT_SELECT_BIT];
	wire nxt_invDat1 = dat3_detect_select & ~d1S2_ff;
	wire invRise    = nxt_invDat1 & ~invDat1_ff;
	wire enRise     = cirqEnabled & ~irqOn_ff;
	wire cardIrqSet = cirqEnabled && (invRise || (enRise && !d1S2_ff));
	wire canTransfer = cardClkEn && clkStable;
	wire descLast   = descValid && descEnd;
	wire descKnown  = descKind == DESC_TRANS || descKind == DESC_LINK || descKind == DESC_NOP;
	wire dmaDone    = xfer_ff == XF_RUN && dataReadDone;

	// Outputs
	assign cardClk      = cardClk_ff;
	assign rdData       = rdData_ff;
	assign cmdStart     = xfer_ff == XF_IDLE && wrXfer && canTransfer;
	assign dmaStep      = xfer_ff == XF_RUN && descValid && descKnown && canTransfer;
	assign sysClkGateEn = ~holdOn;

	// Read mux
	wire [31:0] presentVal = {28'h0, xfer_ff == XF_RUN, d1S2_ff, clkStable, cardInserted} << 0;
	wire [31:0] statVal = ({31'h0, tcFlag_ff} << `TC_BIT) | ({31'h0, dmaFlag_ff} << `DMA_BIT)
		| ({31'h0, cardIrq_ff} << `CIRQ_BIT);
	wire [31:0] presentFix = {presentVal[31:4], clkStable, presentVal[2], d1S2_ff, cardInserted};
	logic [31:0] rdMux;
	always_comb
	begin
		rdMux = 32'h0;
		case (busReq.addr)
			`SYSCTL_OFS:    rdMux = sysctl_ff;
			`PRESENT_OFS:   rdMux = {presentFix[31:3], xfer_ff == XF_RUN, presentFix[1:0]}
				| ({31'h0, clkStable} << `STABLE_BIT);
			`IRQ_STATUS_REG_OFS:   rdMux = statVal;
			`IRQ_STATUS_ENABLE_REG_OFS: rdMux = statEn_ff;
			`IRQ_SIGNAL_ENABLE_REG_OFS:  rdMux = sigEn_ff;
			`PROTOCOL_OFS:  rdMux = protocol_ff;
			default:        rdMux = 32'h0;
		endcase
	end

	// Pin synchronisers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cdS1_ff <= 1'b0;
			cdS2_ff <= 1'b0;
			d1S1_ff <= 1'b1;
			d1S2_ff <= 1'b1;
		end
		else
		begin
			cdS1_ff <= cardDetect;
			cdS2_ff <= cdS1_ff;
			d1S1_ff <= dat1In;
			d1S2_ff <= d1S1_ff;
		end
	end

	// Control registers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sysctl_ff   <= `SYSCTL_RST;
			statEn_ff   <= 32'h0;
			sigEn_ff    <= 32'h0;
			protocol_ff <= `PROTOCOL_RST;
			rdData_ff   <= 32'h0;
		end
		else
		begin
			if (wrSys)
				sysctl_ff <= busReq.wdata & ~(32'h1 << `RSTALL_BIT);
			if (wrStEn)
				statEn_ff <= busReq.wdata;
			if (wrSgEn)
				sigEn_ff <= busReq.wdata;
			if (wrProt)
				protocol_ff <= busReq.wdata;
			rdData_ff <= busReq.rd ? rdMux : 32'h0;
		end
	end

	// Card clock divider and stability counter
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			divCnt_ff    <= '0;
			clkInt_ff    <= 1'b0;
			cardClk_ff   <= 1'b0;
			stableCnt_ff <= 8'(`STABLE_CYC);
		end
		else
		begin
			if (resetAll || divChange)
				stableCnt_ff <= 8'(`STABLE_CYC);
			else if (stableCnt_ff != 8'h00)
				stableCnt_ff <= stableCnt_ff - 8'h01;
			if (divCnt_ff >= divVal)
			begin
				divCnt_ff <= '0;
				clkInt_ff <= ~clkInt_ff;
			end
			else
				divCnt_ff <= divCnt_ff + 1'b1;
			cardClk_ff <= cardClkEn ? clkInt_ff : 1'b0;
		end
	end

	// Transfer sequencer
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			xfer_ff <= XF_IDLE;
		else if (resetAll)
			xfer_ff <= XF_IDLE;
		else
			case (xfer_ff)
				XF_IDLE: if (cmdStart) xfer_ff <= XF_RUN;
				XF_RUN:  if (dmaDone || (dmaStep && descLast)) xfer_ff <= XF_DONE;
				XF_DONE: xfer_ff <= XF_IDLE;
				default: xfer_ff <= XF_IDLE;
			endcase
	end

	// Interrupt status flags, set beats clear
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tcFlag_ff  <= 1'b0;
			dmaFlag_ff <= 1'b0;
			cardIrq_ff <= 1'b0;
			invDat1_ff <= 1'b0;
			irqOn_ff   <= 1'b0;
		end
		else
		begin
			invDat1_ff <= nxt_invDat1;
			irqOn_ff   <= cirqEnabled;
			if (xfer_ff == XF_DONE)
				tcFlag_ff <= 1'b1;
			else if (wrStat && busReq.wdata[`TC_BIT])
				tcFlag_ff <= 1'b0;
			if (xfer_ff == XF_DONE)
				dmaFlag_ff <= 1'b1;
			else if (wrStat && busReq.wdata[`DMA_BIT])
				dmaFlag_ff <= 1'b0;
			if (cardIrqSet)
				cardIrq_ff <= 1'b1;
			else if (wrStat && busReq.wdata[`CIRQ_BIT])
				cardIrq_ff <= 1'b0;
		end
	end

	// Card clock gated while enable is clear
	property p_clk_off;
		@(posedge mclk) disable iff (!rst_n)
		!cardClkEn |=> !cardClk;
	endproperty
	a_clk_off: assert property (p_clk_off) else $error("card clock runs while disabled");

	// Stability drops after divider change
	property p_stable;
		@(posedge mclk) disable iff (!rst_n)
		divChange |=> !clkStable;
	endproperty
	a_stable: assert property (p_stable) else $error("stable not cleared");

	// Reset-all returns sequencer to idle
	property p_rstall;
		@(posedge mclk) disable iff (!rst_n)
		resetAll |=> xfer_ff == XF_IDLE;
	endproperty
	a_rstall: assert property (p_rstall) else $error("operation not abandoned");

	// No command without clock
	property p_nocmd;
		@(posedge mclk) disable iff (!rst_n)
		(cmdStart || dmaStep) |-> cardClkEn;
	endproperty
	a_nocmd: assert property (p_nocmd) else $error("card activity while clock off");

	// Completion sets both flags
	property p_done;
		@(posedge mclk) disable iff (!rst_n)
		xfer_ff == XF_DONE |=> tcFlag_ff && dmaFlag_ff;
	endproperty
	a_done: assert property (p_done) else $error("completion flags missing");

	// Write one clears card interrupt
	property p_w1c;
		@(posedge mclk) disable iff (!rst_n)
		wrStat && busReq.wdata[`CIRQ_BIT] && !cardIrqSet |=> !cardIrq_ff;
	endproperty
	a_w1c: assert property (p_w1c) else $error("card flag not cleared");

	// Select cleared forces inverted level low
	property p_dat3_detect_select;
		@(posedge mclk) disable iff (!rst_n)
		!dat3_detect_select |=> !invDat1_ff;
	endproperty
	a_dat3_detect_select: assert property (p_dat3_detect_select) else $error("inverted DAT1 not forced low");

	// Enable with DAT1 already low sets flag
	property p_level;
		@(posedge mclk) disable iff (!rst_n)
		(enRise && !d1S2_ff) |=> cardIrq_ff;
	endproperty
	a_level: assert property (p_level) else $error("level interrupt missed");

	// Gating follows hold control
	property p_hold;
		@(posedge mclk) disable iff (!rst_n)
		holdOn |-> !sysClkGateEn;
	endproperty
	a_hold: assert property (p_hold) else $error("gating while hold on");

	// Gating allowed again once hold is cleared
	property p_gate;
		@(posedge mclk) disable iff (!rst_n)
		!holdOn |-> sysClkGateEn;
	endproperty
	a_gate: assert property (p_gate) else $error("gating blocked without hold");

	// Any TRANS, LINK or NOP descriptor carrying End closes the chain
	property p_last;
		@(posedge mclk) disable iff (!rst_n)
		dmaStep && descLast && !resetAll |=> xfer_ff == XF_DONE;
	endproperty
	a_last: assert property (p_last) else $error("chain not closed at end descriptor");

	// Present state read returns the synchronised detect level
	property p_present;
		@(posedge mclk) disable iff (!rst_n)
		busReq.rd && busReq.addr == `PRESENT_OFS |=> rdData[`CDET_BIT] == $past(cardInserted);
	endproperty
	a_present: assert property (p_present) else $error("detect level misreported");

	// Software clear of the DMA flag works outside completion
	property p_dmaclr;
		@(posedge mclk) disable iff (!rst_n)
		wrStat && busReq.wdata[`DMA_BIT] && xfer_ff != XF_DONE |=> !dmaFlag_ff;
	endproperty
	a_dmaclr: assert property (p_dmaclr) else $error("dma flag not cleared");

	// Rising inverted DAT1 while enabled sets the card flag
	property p_cirq;
		@(posedge mclk) disable iff (!rst_n)
		cirqEnabled && invRise |=> cardIrq_ff;
	endproperty
	a_cirq: assert property (p_cirq) else $error("card interrupt edge missed");

	// Card flag stays clear while either enable is off
	property p_cmask;
		@(posedge mclk) disable iff (!rst_n)
		!cirqEnabled && !cardIrq_ff |=> !cardIrq_ff;
	endproperty
	a_cmask: assert property (p_cmask) else $error("card flag set while masked");
endmodule // sd_host_control
`default_nettype wire

// [src/sd_host_map.svh]
`ifndef SD_HOST_MAP_SVH
`define SD_HOST_MAP_SVH
// Register offsets (byte addresses)
`define SYSCTL_OFS     8'h00
`define PRESENT_OFS    8'h04
`define IRQ_STATUS_REG_OFS    8'h08
`define IRQ_STATUS_ENABLE_REG_OFS  8'h0c
`define IRQ_SIGNAL_ENABLE_REG_OFS   8'h10
`define PROTOCOL_OFS   8'h14
`define XFER_OFS       8'h18
// Field positions
`define CLKEN_BIT      3
`define RSTALL_BIT     0
`define HOLD_BIT       1
`define DIVLO_BIT      8
`define STABLE_BIT     3
`define CDET_BIT       0
`define DAT1_BIT       1
`define BUSY_BIT       2
`define TC_BIT         1
`define DMA_BIT        3
`define CIRQ_BIT       8
`define DAT3_DETECT_SELECT_BIT       3
// Reset values
`define SYSCTL_RST     32'h0000_0000
`define PROTOCOL_RST   32'h0000_0008
// Timing
`define STABLE_NS      500
`define CLK_NS         50
`define STABLE_CYC     ((`STABLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [src/sd_host_pkg.sv]
package sd_host_pkg;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;
	typedef enum logic [2:0] {
		XF_IDLE = 3'b001,
		XF_RUN  = 3'b010,
		XF_DONE = 3'b100
	} xfer_state_t;
	typedef enum logic [1:0] {
		DESC_NOP   = 2'b00,
		DESC_RSV   = 2'b01,
		DESC_TRANS = 2'b10,
		DESC_LINK  = 2'b11
	} desc_kind_t;
endpackage

// [tb/sd_card_model.sv]
`timescale 1ns/1ns
`default_nettype none
module sd_card_model (
	// Test controls
	input  wire logic present,
	input  wire logic irqReq,
	input  wire logic discharge,
	// Card pins
	output logic      cardDetect,
	output logic      dat1
);
	// Weak pull-down cannot bring a once-high detect line back low
	logic charged = 1'b0;
	// Line keeps its charge until the pin is driven low as an output
	always @(present or discharge)
	begin
		if (discharge)
			charged = 1'b0;
		else if (present)
			charged = 1'b1;
	end
	// Card pull-up beats the pull-down; a pin driven low beats both
	assign cardDetect = !discharge && (present || charged);
	// Interrupt pulls DAT1 low, pull-up holds it high otherwise
	assign dat1 = !(present && irqReq);
endmodule // sd_card_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sd_host_map.svh"
module testbench;
	import sd_host_pkg::*;
	localparam logic [31:0] CI = 32'h1 << `CIRQ_BIT;
	localparam logic [31:0] DM = (32'h1 << `TC_BIT) | (32'h1 << `DMA_BIT);
	localparam logic [31:0] EN = 32'h1 << `CLKEN_BIT;
	localparam logic [31:0] ST = 32'h1 << `STABLE_BIT;
	localparam logic [31:0] BZ = 32'h1 << `BUSY_BIT;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	bus_req_t    busReq = '0;
	logic [31:0] rdData;
	logic        present = 1'b0;
	logic        irqReq = 1'b0;
	logic        discharge = 1'b0;
	logic        descValid = 1'b0;
	logic        descEnd = 1'b0;
	logic [1:0]  descKind = 2'b00;
	logic        dataReadDone = 1'b0;
	logic        cardDetect, dat1In, cardClk, cmdStart, dmaStep, sysClkGateEn;
	logic [31:0] got;
	logic        lastClk = 1'b0;
	int          errors = 0;
	int          samples_checked = 0;
	int          cmdSeen = 0;
	int          stepSeen = 0;
	int          clkEdges = 0;
	int          n;
	sd_card_model card_u (.present(present), .irqReq(irqReq), .discharge(discharge),
		.cardDetect(cardDetect), .dat1(dat1In));
	sd_host_control dut_u (.mclk(mclk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
		.cardDetect(cardDetect), .dat1In(dat1In), .cardClk(cardClk), .cmdStart(cmdStart),
		.descValid(descValid), .descKind(descKind), .descEnd(descEnd),
		.dataReadDone(dataReadDone), .dmaStep(dmaStep), .sysClkGateEn(sysClkGateEn));
	always #25 mclk = ~mclk;
	// Count command pulses and card clock transitions
	always @(posedge mclk)
	begin
		if (cmdStart === 1'b1)
			cmdSeen <= cmdSeen + 1;
		if (dmaStep === 1'b1)
			stepSeen <= stepSeen + 1;
		if (rst_n && cardClk !== lastClk)
			clkEdges <= clkEdges + 1;
		lastClk <= cardClk;
	end
	task complete_run;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		busReq.wr <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
		@(posedge mclk);
		busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		busReq.rd <= 1'b0;
		#1 got = rdData;
		chk(got & m, e, s);
	endtask
	task cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask
	// Bounded poll of the clock stable flag
	task waitStable;
		int i;
		for (i = 0; i < 40; i++)
		begin
			rdchk(`PRESENT_OFS, 32'h0, 32'h0, "poll");
			if (got[`STABLE_BIT] === 1'b1)
				break;
		end
		chk(i < 40, 32'h1, "stable timeout");
	endtask
	task desc(input logic [1:0] k, input logic e);
		@(posedge mclk);
		descValid <= 1'b1;
		descKind <= k;
		descEnd <= e;
		@(posedge mclk);
		descValid <= 1'b0;
		descEnd <= 1'b0;
	endtask
	initial
	begin
		#1000000;
		errors++;
		complete_run;
	end
	initial
	begin
		cyc(3);
		rst_n <= 1'b1;
		rdchk(`SYSCTL_OFS, 32'hffff_ffff, `SYSCTL_RST, "sysctl");
		rdchk(`PROTOCOL_OFS, 32'hffff_ffff, `PROTOCOL_RST, "protocol");
		rdchk(8'h1c, 32'hffff_ffff, 32'h0, "unmapped");
		chk(sysClkGateEn, 32'h1, "gating");
		waitStable();
		wr(`XFER_OFS, 32'h0);
		cyc(2);
		chk(cmdSeen, 32'h0, "cmd clock off");
		rdchk(`PRESENT_OFS, BZ, 32'h0, "busy clock off");
		chk(clkEdges, 32'h0, "clock off");
		wr(`SYSCTL_OFS, EN);
		cyc(4);
		chk(clkEdges != 0, 32'h1, "clock on");
		wr(`XFER_OFS, 32'h0);
		cyc(1);
		chk(cmdSeen, 32'h1, "cmd");
		rdchk(`PRESENT_OFS, BZ, BZ, "busy");
		// Recommended order: clock off, reset, poll, clock on
		wr(`SYSCTL_OFS, 32'h0);
		cyc(3);
		n = clkEdges;
		wr(`SYSCTL_OFS, 32'h1 << `RSTALL_BIT);
		rdchk(`PRESENT_OFS, BZ | ST, 32'h0, "reset all");
		chk(clkEdges, n, "clock stopped");
		waitStable();
		wr(`SYSCTL_OFS, 32'h0000_0200);
		rdchk(`PRESENT_OFS, ST, 32'h0, "divider");
		waitStable();
		present <= 1'b1;
		cyc(3);
		rdchk(`PRESENT_OFS, 32'h1, 32'h1, "inserted");
		// Removal leaves the line charged until the pin is driven low
		present <= 1'b0;
		discharge <= 1'b1;
		cyc(4);
		discharge <= 1'b0;
		cyc(3);
		rdchk(`PRESENT_OFS, 32'h1, 32'h0, "removed");
		wr(`SYSCTL_OFS, EN | (32'h1 << `HOLD_BIT) | 32'h0000_0200);
		cyc(1);
		chk(sysClkGateEn, 32'h0, "hold");
		// DMA ends once by data done, once by TRANS with End
		for (int k = 0; k < 2; k++)
		begin
			wr(`XFER_OFS, 32'h0);
			desc(DESC_NOP, 1'b0);
			desc(DESC_LINK, 1'b0);
			rdchk(`IRQ_STATUS_REG_OFS, DM, 32'h0, "early done");
			if (k == 1)
				desc(DESC_TRANS, 1'b1);
			else
			begin
				@(posedge mclk) dataReadDone <= 1'b1;
				@(posedge mclk) dataReadDone <= 1'b0;
			end
			cyc(2);
			rdchk(`IRQ_STATUS_REG_OFS, DM, DM, "dma done");
			wr(`IRQ_STATUS_REG_OFS, DM);
			rdchk(`IRQ_STATUS_REG_OFS, DM, 32'h0, "dma clear");
		end
		chk(stepSeen, 32'h5, "descriptor steps");
		wr(`SYSCTL_OFS, EN | 32'h0000_0200);
		cyc(1);
		chk(sysClkGateEn, 32'h1, "unhold");
		present <= 1'b1;
		wr(`IRQ_STATUS_ENABLE_REG_OFS, CI);
		irqReq <= 1'b1;
		cyc(4);
		rdchk(`IRQ_STATUS_REG_OFS, CI, 32'h0, "one enable");
		wr(`IRQ_SIGNAL_ENABLE_REG_OFS, CI);
		cyc(3);
		rdchk(`IRQ_STATUS_REG_OFS, CI, CI, "level at enable");
		wr(`IRQ_STATUS_ENABLE_REG_OFS, 32'h0);
		wr(`IRQ_SIGNAL_ENABLE_REG_OFS, 32'h0);
		wr(`IRQ_STATUS_REG_OFS, CI);
		rdchk(`IRQ_STATUS_REG_OFS, CI, 32'h0, "w1c");
		wr(`PROTOCOL_OFS, 32'h0);
		wr(`PROTOCOL_OFS, `PROTOCOL_RST);
		wr(`IRQ_STATUS_ENABLE_REG_OFS, CI);
		wr(`IRQ_SIGNAL_ENABLE_REG_OFS, CI);
		cyc(3);
		rdchk(`IRQ_STATUS_REG_OFS, CI, CI, "still low");
		irqReq <= 1'b0;
		cyc(3);
		wr(`IRQ_STATUS_REG_OFS, CI);
		rdchk(`IRQ_STATUS_REG_OFS, CI, 32'h0, "w1c high");
		irqReq <= 1'b1;
		cyc(4);
		rdchk(`IRQ_STATUS_REG_OFS, CI, CI, "falling dat1");
		rdchk(`PRESENT_OFS, 32'h1, 32'h1, "present again");
		complete_run;
	end
endmodule // testbench
`default_nettype wire
